/* File: inc/abc_defs.vh */
/*
  constants of the address break comparator: register offsets, field
  positions, reset values and encodings.
  assumes an APB slave with 32-bit data, one aligned word per register.
*/
//
// Contract
// - control bit 7 resets 1; at 0, hold off interrupts one instruction after return
// - cycle select 00 execute, 01 read, 10 write, 11 read or write
// - address compare 000 all 16, 001 upper 12, 010 upper 8, 011 upper 4 bits
// - data compare 00 off, 01 low break byte, 11 full 16 bits
// - data compare 10 matches high break byte against upper bus half
// - upper lane for even words and bytes, lower lane for odd words
// - 8-bit I/O always upper lane; word access seen as two byte accesses
// - status bit 7 flag resets 0, set when all programmed conditions match
// - flag clears only by writing 0 after reading it as 1
// - status bit 6 enable resets 0; request only while it is 1
// - status bits 5 to 0 read as 1, writes ignored
// - break address is 16 bits, high and low bytes, resets to all ones
// - break data 16 bits; high byte vs upper bus, low byte vs lower bus
// - break data has no reset value
// - request break interrupt while flag and enable are both 1, unmaskable
`ifndef ABC_DEFS_VH
`define ABC_DEFS_VH

`define ABC_OFF_CTRL      8'h00
`define ABC_OFF_STAT      8'h04
`define ABC_OFF_ADDR_HI   8'h08
`define ABC_OFF_ADDR_LO   8'h0c
`define ABC_OFF_DATA_HI   8'h10
`define ABC_OFF_DATA_LO   8'h14

`define ABC_CTRL_UNMASK   7
`define ABC_CSEL_HI       6
`define ABC_CSEL_LO       5
`define ABC_ACMP_HI       4
`define ABC_ACMP_LO       2
`define ABC_DCMP_HI       1
`define ABC_DCMP_LO       0

`define ABC_STAT_FLAG     7
`define ABC_STAT_EN       6
`define ABC_STAT_RSVD     6'h3f

`define ABC_CTRL_RST      8'h80
`define ABC_ADDR_RST      16'hffff

`define ABC_CSEL_EXEC     2'h0
`define ABC_CSEL_READ     2'h1
`define ABC_CSEL_WRITE    2'h2
`define ABC_CSEL_RDWR     2'h3

`define ABC_ACMP_16       3'h0
`define ABC_ACMP_12       3'h1
`define ABC_ACMP_8        3'h2
`define ABC_ACMP_4        3'h3
`define ABC_ACMP_RSVD     2

`define ABC_DCMP_OFF      2'h0
`define ABC_DCMP_LOW      2'h1
`define ABC_DCMP_HIGH     2'h2
`define ABC_DCMP_FULL     2'h3

`define ABC_MASK_16       16'hffff
`define ABC_MASK_12       16'hfff0
`define ABC_MASK_8        16'hff00
`define ABC_MASK_4        16'hf000
`define ABC_MASK_NONE     16'h0000

`endif

/* File: rtl/abc_lane_match.v */
/*
  data lane comparison of the address break comparator.
  assumes the cpu drives byte data on the upper lane and odd word bytes on
  the lower lane, one byte per bus cycle.
*/
`timescale 1ns/1ps
`include "abc_defs.vh"

module abc_lane_match (
  breakData,
  busData,
  laneSel,
  byteAccess,
  io8Access,
  addrLsb,
  hit
);
  input  wire [15:0] breakData;
  input  wire [15:0] busData;
  input  wire [1:0]  laneSel;
  input  wire        byteAccess;
  input  wire        io8Access;
  input  wire        addrLsb;
  output reg         hit;

  wire upperActive;
  wire lowerActive;

  // upper lane for bytes, 8-bit i/o and even words
  assign upperActive = byteAccess | io8Access | ~addrLsb;
  assign lowerActive = ~upperActive;

  always @* begin
    case (laneSel)
      `ABC_DCMP_OFF: hit = 1'b1;
      `ABC_DCMP_LOW: hit = lowerActive & (busData[7:0] == breakData[7:0]);
      `ABC_DCMP_HIGH: hit = upperActive & (busData[15:8] == breakData[15:8]);
      `ABC_DCMP_FULL: hit = (busData == breakData);
      default: hit = 1'b0;
    endcase
  end
endmodule

/* File: rtl/abc_top.v */
/*
  address break comparator: apb register file, bus cycle matcher, break
  flag, unmaskable break request and return hold-off.
  assumes cpu bus signals and apb run on clk; cycle strobes are single
  cycle pulses from the cpu core.
*/
`timescale 1ns/1ps
`include "abc_defs.vh"

module abc_top #(
  parameter ADDR_W = 8
) (
  clk,
  rst_n,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  cpuCycleValid,
  cpuFetch,
  cpuRead,
  cpuWrite,
  cpuByte,
  cpuIo8,
  cpuAddr,
  cpuData,
  rteDone,
  instrDone,
  breakIrq,
  breakFlag,
  rteIrqHold
);
  input  wire              clk;
  input  wire              rst_n;
  input  wire              psel;
  input  wire              penable;
  input  wire              pwrite;
  input  wire [ADDR_W-1:0] paddr;
  input  wire [31:0]       pwdata;
  output reg  [31:0]       prdata;
  output reg               pready;
  output reg               pslverr;
  input  wire              cpuCycleValid;
  input  wire              cpuFetch;
  input  wire              cpuRead;
  input  wire              cpuWrite;
  input  wire              cpuByte;
  input  wire              cpuIo8;
  input  wire [15:0]       cpuAddr;
  input  wire [15:0]       cpuData;
  input  wire              rteDone;
  input  wire              instrDone;
  output reg               breakIrq;
  output reg               breakFlag;
  output reg               rteIrqHold;

  // apb slave states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACK  = 2'b10;

  // register index codes
  localparam [2:0] IX_CTRL  = 3'h0;
  localparam [2:0] IX_STAT  = 3'h1;
  localparam [2:0] IX_ADRH  = 3'h2;
  localparam [2:0] IX_ADRL  = 3'h3;
  localparam [2:0] IX_DATH  = 3'h4;
  localparam [2:0] IX_DATL  = 3'h5;
  localparam [2:0] IX_NONE  = 3'h7;

  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [7:0]  ctrl_reg;
  reg [15:0] addr_reg;
  reg [15:0] data_reg;
  reg        flag_reg;
  reg        flag_next;
  reg        enable_reg;
  reg        armed_reg;
  reg        armed_next;
  reg        hold_reg;
  reg        hold_next;
  reg [31:0] rdata_next;

  wire [1:0]  cycleSel;
  wire [2:0]  addrWidth;
  wire [1:0]  laneSel;
  wire        unmask;
  wire [2:0]  regIx;
  wire        access;
  wire        done;
  wire        wrDone;
  wire        rdDone;
  wire        cycleHit;
  wire        addrHit;
  wire        dataHit;
  wire        dataCycle;
  wire        match;
  wire [7:0]  statByte;
  // decoded register strobes
  wire        wrCtrl;
  wire        wrStat;
  wire        wrAdrH;
  wire        wrAdrL;
  wire        wrDatH;
  wire        wrDatL;
  wire        rdStat;
  wire [15:0] cmpMask;

  // word offset to register index
  function [2:0] decodeIx;
    input [ADDR_W-1:0] a;
    begin
      case (a)
        `ABC_OFF_CTRL:    decodeIx = IX_CTRL;
        `ABC_OFF_STAT:    decodeIx = IX_STAT;
        `ABC_OFF_ADDR_HI: decodeIx = IX_ADRH;
        `ABC_OFF_ADDR_LO: decodeIx = IX_ADRL;
        `ABC_OFF_DATA_HI: decodeIx = IX_DATH;
        `ABC_OFF_DATA_LO: decodeIx = IX_DATL;
        default:          decodeIx = IX_NONE;
      endcase
    end
  endfunction

  // address compare width to mask
  function [15:0] addrMask;
    input [2:0] w;
    begin
      case (w)
        `ABC_ACMP_16: addrMask = `ABC_MASK_16;
        `ABC_ACMP_12: addrMask = `ABC_MASK_12;
        `ABC_ACMP_8:  addrMask = `ABC_MASK_8;
        `ABC_ACMP_4:  addrMask = `ABC_MASK_4;
        default:      addrMask = `ABC_MASK_NONE;
      endcase
    end
  endfunction

  // control fields
  assign unmask    = ctrl_reg[`ABC_CTRL_UNMASK];
  assign cycleSel  = ctrl_reg[`ABC_CSEL_HI:`ABC_CSEL_LO];
  assign addrWidth = ctrl_reg[`ABC_ACMP_HI:`ABC_ACMP_LO];
  assign laneSel   = ctrl_reg[`ABC_DCMP_HI:`ABC_DCMP_LO];

  // apb access decode
  assign regIx  = decodeIx(paddr);
  assign access = psel & penable;
  assign done   = access & state_reg[1];
  assign wrDone = done & pwrite;
  assign rdDone = done & ~pwrite;

  // per register strobes, one per completed access
  assign wrCtrl = wrDone & (regIx == IX_CTRL);
  assign wrStat = wrDone & (regIx == IX_STAT);
  assign wrAdrH = wrDone & (regIx == IX_ADRH);
  assign wrAdrL = wrDone & (regIx == IX_ADRL);
  assign wrDatH = wrDone & (regIx == IX_DATH);
  assign wrDatL = wrDone & (regIx == IX_DATL);
  assign rdStat = rdDone & (regIx == IX_STAT);

  // reserved status bits read as ones
  assign statByte = {flag_reg, enable_reg, `ABC_STAT_RSVD};

  // cycle type qualification
  function cycleMatch;
    input [1:0] sel;
    input       fetch;
    input       rd;
    input       wr;
    begin
      case (sel)
        `ABC_CSEL_EXEC:  cycleMatch = fetch;
        `ABC_CSEL_READ:  cycleMatch = rd;
        `ABC_CSEL_WRITE: cycleMatch = wr;
        `ABC_CSEL_RDWR:  cycleMatch = rd | wr;
        default:         cycleMatch = 1'b0;
      endcase
    end
  endfunction

  assign dataCycle = cpuRead | cpuWrite;
  assign cycleHit  = cycleMatch(cycleSel, cpuFetch, cpuRead, cpuWrite);

  // masked address compare, reserved widths never hit
  assign cmpMask = addrMask(addrWidth);
  assign addrHit = ~addrWidth[`ABC_ACMP_RSVD] &
    (((cpuAddr ^ addr_reg) & cmpMask) == `ABC_MASK_NONE);

  abc_lane_match u_lane (
    .breakData  (data_reg),
    .busData    (cpuData),
    .laneSel    (laneSel),
    .byteAccess (cpuByte),
    .io8Access  (cpuIo8),
    .addrLsb    (cpuAddr[0]),
    .hit        (dataHit)
  );

  // all conditions within one bus cycle; data only on data cycles
  assign match = cpuCycleValid & cycleHit & addrHit &
    (~dataCycle | dataHit);

  // apb handshake
  always @* begin
    case (state_reg)
      ST_IDLE: state_next = access ? ST_ACK : ST_IDLE;
      ST_ACK:  state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @* begin
    case (regIx)
      IX_CTRL: rdata_next = {24'h000000, ctrl_reg};
      IX_STAT: rdata_next = {24'h000000, statByte};
      IX_ADRH: rdata_next = {24'h000000, addr_reg[15:8]};
      IX_ADRL: rdata_next = {24'h000000, addr_reg[7:0]};
      IX_DATH: rdata_next = {24'h000000, data_reg[15:8]};
      IX_DATL: rdata_next = {24'h000000, data_reg[7:0]};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // status read with the flag up arms the clear; any status write disarms
  always @* begin
    armed_next = armed_reg;
    if (rdStat && flag_reg) begin
      armed_next = 1'b1;
    end
    if (wrStat) begin
      armed_next = 1'b0;
    end
  end

  // flag: set wins over the clearing write
  always @* begin
    flag_next = flag_reg;
    if (wrStat && armed_reg && !pwdata[`ABC_STAT_FLAG]) begin
      flag_next = 1'b0;
    end
    if (match) begin
      flag_next = 1'b1;
    end
  end

  // return hold-off for one instruction
  always @* begin
    hold_next = hold_reg;
    if (rteDone && !unmask) begin
      hold_next = 1'b1;
    end else if (instrDone || unmask) begin
      hold_next = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      state_reg <= state_next;
      pready    <= state_next[1];
      pslverr   <= state_next[1] & (regIx == IX_NONE);
    end
  end

  // read data loads in the first access cycle, stands until the next load
  always @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (access && state_reg[0]) begin
      prdata <= pwrite ? 32'h00000000 : rdata_next;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= `ABC_CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      addr_reg <= `ABC_ADDR_RST;
    end else begin
      if (wrAdrH) begin
        addr_reg[15:8] <= pwdata[7:0];
      end
      if (wrAdrL) begin
        addr_reg[7:0] <= pwdata[7:0];
      end
    end
  end

  // break data carries no reset value
  always @(posedge clk) begin
    if (wrDatH) begin
      data_reg[15:8] <= pwdata[7:0];
    end
    if (wrDatL) begin
      data_reg[7:0] <= pwdata[7:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      flag_reg  <= 1'b0;
      armed_reg <= 1'b0;
      hold_reg  <= 1'b0;
    end else begin
      flag_reg  <= flag_next;
      armed_reg <= armed_next;
      hold_reg  <= hold_next;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      enable_reg <= 1'b0;
    end else if (wrStat) begin
      enable_reg <= pwdata[`ABC_STAT_EN];
    end
  end

  // outputs one cycle behind the status bits and the hold register
  always @(posedge clk) begin
    if (!rst_n) begin
      breakIrq   <= 1'b0;
      breakFlag  <= 1'b0;
      rteIrqHold <= 1'b0;
    end else begin
      breakIrq   <= flag_reg & enable_reg;
      breakFlag  <= flag_reg;
      rteIrqHold <= hold_reg;
    end
  end
endmodule

/* File: sim/abc_top_properties.sv */
/* port checker of the address break comparator.
   assumes one clock domain, rst_n synchronous and active low. */
`timescale 1ns/1ps
`include "abc_defs.vh"
module abc_top_props #(
  parameter ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              cpuCycleValid,
  input wire logic              rteDone,
  input wire logic              breakIrq,
  input wire logic              breakFlag,
  input wire logic              rteIrqHold
);
  logic clrWr;
  assign clrWr = psel && penable && pready && pwrite && paddr == `ABC_OFF_STAT &&
    !pwdata[`ABC_STAT_FLAG];
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_rdy;
    psel && !penable |=> !pready ##1 pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready timing");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rsvd;
    psel && penable && pready && !pwrite && paddr == `ABC_OFF_STAT
      |-> prdata[5:0] == `ABC_STAT_RSVD && prdata[31:8] == 24'h000000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("status filler bits");
  property p_irq;
    breakIrq |-> breakFlag;
  endproperty
  a_irq: assert property (p_irq) else $error("request without flag");
  property p_set;
    $rose(breakFlag) |-> $past(cpuCycleValid, 2);
  endproperty
  a_set: assert property (p_set) else $error("flag without cycle");
  property p_clr;
    $fell(breakFlag) && $past(rst_n) |-> $past(clrWr, 2);
  endproperty
  a_clr: assert property (p_clr) else $error("flag cleared unasked");
  property p_rte;
    $rose(rteIrqHold) |-> $past(rteDone, 2);
  endproperty
  a_rte: assert property (p_rte) else $error("hold without return");
  property p_rst;
    $rose(rst_n) |-> !breakFlag && !breakIrq && !rteIrqHold && !pready;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs after reset");
endmodule

/* File: sim/abc_cpu_model.sv */
/* cpu side model: single bus cycles and instruction end pulses.
   assumes each task starts right after a rising clk edge. */
`timescale 1ns/1ps
module abc_cpu_model (
  input  wire logic   clk,
  output logic        cpuCycleValid,
  output logic        cpuFetch,
  output logic        cpuRead,
  output logic        cpuWrite,
  output logic        cpuByte,
  output logic        cpuIo8,
  output logic [15:0] cpuAddr,
  output logic [15:0] cpuData,
  output logic        rteDone,
  output logic        instrDone
);
  initial begin
    {cpuCycleValid, cpuFetch, cpuRead, cpuWrite, cpuByte, cpuIo8} = 6'h00;
    {rteDone, instrDone} = 2'h0;
    cpuAddr = 16'h0000;
    cpuData = 16'h0000;
  end
  // one cycle; released buses show inverted values
  task cyc(input logic [4:0] k, input logic [15:0] a, input logic [15:0] d);
    {cpuFetch, cpuRead, cpuWrite, cpuByte, cpuIo8} <= k;
    cpuAddr <= a;
    cpuData <= d;
    cpuCycleValid <= 1'b1;
    @(posedge clk);
    cpuCycleValid <= 1'b0;
    cpuAddr <= ~a;
    cpuData <= ~d;
  endtask
  // every instruction end pulses instrDone, a return pulses rteDone with it
  task pulse(input logic r);
    rteDone <= r;
    instrDone <= 1'b1;
    @(posedge clk);
    rteDone <= 1'b0;
    instrDone <= 1'b0;
  endtask
endmodule

/* File: sim/tb_abc_top.sv */
/* bench of the address break comparator: apb tasks and break probes.
   assumes the cpu bus model and the port checker beside the design. */
`timescale 1ns/1ps
`include "abc_defs.vh"
module tb_abc_top;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err, e;
  logic        cpuCycleValid, cpuFetch, cpuRead, cpuWrite, cpuByte, cpuIo8;
  logic        rteDone, instrDone, breakIrq, breakFlag, rteIrqHold;
  logic [7:0]  paddr, q;
  logic [15:0] cpuAddr, cpuData;
  logic [31:0] pwdata, prdata;
  int          num_errors, checks, c, m;
  abc_top #(.ADDR_W(8)) u_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpuCycleValid(cpuCycleValid), .cpuFetch(cpuFetch), .cpuRead(cpuRead),
    .cpuWrite(cpuWrite), .cpuByte(cpuByte), .cpuIo8(cpuIo8), .cpuAddr(cpuAddr),
    .cpuData(cpuData), .rteDone(rteDone), .instrDone(instrDone), .breakIrq(breakIrq),
    .breakFlag(breakFlag), .rteIrqHold(rteIrqHold)
  );
  abc_cpu_model u_cpu (
    .clk(clk), .cpuCycleValid(cpuCycleValid), .cpuFetch(cpuFetch), .cpuRead(cpuRead),
    .cpuWrite(cpuWrite), .cpuByte(cpuByte), .cpuIo8(cpuIo8), .cpuAddr(cpuAddr),
    .cpuData(cpuData), .rteDone(rteDone), .instrDone(instrDone)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task results;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #400us;
    num_errors++;
    results();
  end
  task chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    checks++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", nm, x, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk("reg", x, q);
  endtask
  task probe(input logic [7:0] cr, input logic [4:0] k, input logic [15:0] a, d, input logic x);
    apb(1'b1, `ABC_OFF_CTRL, cr);
    u_cpu.cyc(k, a, d);
    repeat (2) @(posedge clk);
    chk("flag", {7'h00, x}, {7'h00, breakFlag});
    chk("irq", {7'h00, x}, {7'h00, breakIrq});
    rd(`ABC_OFF_STAT, {x, 7'h7f});
    apb(1'b1, `ABC_OFF_STAT, 8'h40);
  endtask
  initial begin
    {psel, penable, pwrite, rst_n} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    num_errors = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`ABC_OFF_CTRL, `ABC_CTRL_RST);
    rd(`ABC_OFF_STAT, 8'h3f);
    rd(`ABC_OFF_ADDR_HI, 8'hff);
    rd(8'h18, 8'h00);
    chk("slverr", 8'h01, {7'h00, err});
    apb(1'b1, `ABC_OFF_ADDR_HI, 8'h12);
    apb(1'b1, `ABC_OFF_ADDR_LO, 8'h34);
    rd(`ABC_OFF_ADDR_LO, 8'h34);
    rd(`ABC_OFF_ADDR_HI, 8'h12);
    apb(1'b1, `ABC_OFF_DATA_HI, 8'ha5);
    apb(1'b1, `ABC_OFF_DATA_LO, 8'h3c);
    rd(`ABC_OFF_DATA_LO, 8'h3c);
    rd(`ABC_OFF_DATA_HI, 8'ha5);
    apb(1'b1, `ABC_OFF_STAT, 8'h7f);
    rd(`ABC_OFF_STAT, 8'h7f);
    for (c = 0; c < 4; c++) begin
      for (m = 0; m < 3; m++) begin
        e = c == 3 ? m != 0 : c == m;
        probe({1'b1, c[1:0], 5'h00}, 5'h10 >> m, 16'h1234, 16'h0000, e);
      end
    end
    for (m = 0; m < 4; m++) begin
      probe({3'h5, m[2:0], 2'h0}, 5'h08, 16'h1235, 16'h0000, m != 0);
      probe({3'h5, m[2:0], 2'h0}, 5'h08, 16'h1334, 16'h0000, m == 3);
    end
    probe(8'ha6, 5'h08, 16'h1234, 16'ha500, 1'b1);
    probe(8'ha6, 5'h08, 16'h1234, 16'h5aa5, 1'b0);
    probe(8'ha5, 5'h08, 16'h1234, 16'h003c, 1'b0);
    probe(8'ha5, 5'h08, 16'h1235, 16'h003c, 1'b1);
    probe(8'ha6, 5'h0a, 16'h1235, 16'ha500, 1'b1);
    probe(8'he6, 5'h05, 16'h1235, 16'ha500, 1'b1);
    probe(8'ha7, 5'h08, 16'h1234, 16'ha53c, 1'b1);
    probe(8'ha7, 5'h08, 16'h1234, 16'ha53d, 1'b0);
    apb(1'b1, `ABC_OFF_STAT, 8'h00);
    u_cpu.cyc(5'h08, 16'h1234, 16'ha53c);
    repeat (2) @(posedge clk);
    chk("irq", 8'h00, {7'h00, breakIrq});
    apb(1'b1, `ABC_OFF_STAT, 8'h40);
    @(posedge clk);
    chk("flag", 8'h01, {7'h00, breakFlag});
    chk("irq", 8'h01, {7'h00, breakIrq});
    rd(`ABC_OFF_STAT, 8'hff);
    apb(1'b1, `ABC_OFF_STAT, 8'h40);
    rd(`ABC_OFF_STAT, 8'h7f);
    apb(1'b1, `ABC_OFF_CTRL, 8'h00);
    u_cpu.pulse(1'b1);
    repeat (2) @(posedge clk);
    chk("hold", 8'h01, {7'h00, rteIrqHold});
    u_cpu.pulse(1'b0);
    repeat (2) @(posedge clk);
    chk("hold", 8'h00, {7'h00, rteIrqHold});
    u_cpu.pulse(1'b1);
    apb(1'b1, `ABC_OFF_CTRL, `ABC_CTRL_RST);
    repeat (2) @(posedge clk);
    chk("hold", 8'h00, {7'h00, rteIrqHold});
    u_cpu.pulse(1'b1);
    repeat (2) @(posedge clk);
    chk("hold", 8'h00, {7'h00, rteIrqHold});
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`ABC_OFF_ADDR_LO, 8'hff);
    rd(`ABC_OFF_STAT, 8'h3f);
    results();
  end
endmodule
bind abc_top abc_top_props #(.ADDR_W(ADDR_W)) u_props (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpuCycleValid(cpuCycleValid), .rteDone(rteDone), .breakIrq(breakIrq),
  .breakFlag(breakFlag), .rteIrqHold(rteIrqHold)
);
